// >>> include/arith_decode_pkg.sv
// Package with opcode patterns, field positions and clock counts for the arithmetic decoder.
// Summary of operation
// - 000110dw with mod/reg/rm: subtract with borrow, 2 clocks register, 7 memory.
// - 100000sw reg 011: subtract immediate with borrow; second byte when s,w=01; 3/7.
// - 0001110w: subtract immediate with borrow from accumulator; word immediate if w; 3.
// - 1111111w reg 001: decrement register or memory, 2 or 7 clocks.
// - 0011101w with mod/reg/rm: compare, flags only, 2 or 6 clocks.
// - Immediate group, reg 111: compare immediate, 3 or 6 clocks.
// - 1111011w reg 011: negate, 2 clocks for a register operand.
// - Four single-byte decimal and ascii adjust add/sub operations take 3 clocks.
// - 1111011w reg 100: unsigned multiply of the accumulator.
// - Unsigned multiply: 21 register word, 16 memory byte, 24 memory word.
// - 1111011w reg 101: signed multiply of the accumulator.
// - Signed multiply: 13 register byte, 16 memory byte, 24 memory word.
// - 011010s1: signed immediate multiply; second byte when s=0; 21 or 24 clocks.
// - 1111011w reg 110: unsigned divide of the accumulator.
// - Unsigned divide: 14 register byte, 22 register word, 17 memory byte.
package arith_decode_pkg;

  typedef enum logic [3:0] {
    OP_NONE,
    OP_SUBTRACT_WITH_BORROW,
    OP_DECREMENT,
    OP_COMPARE,
    OP_NEGATE,
    OP_ASCII_ADJUST_ADD,
    OP_DECIMAL_ADJUST_ADD,
    OP_ASCII_ADJUST_SUB,
    OP_DECIMAL_ADJUST_SUB,
    OP_UNSIGNED_MULTIPLY,
    OP_SIGNED_MULTIPLY,
    OP_SIGNED_MULTIPLY_IMM,
    OP_UNSIGNED_DIVIDE
  } op_kind_e;

  typedef enum logic [2:0] {
    ST_OPCODE,
    ST_MODRM,
    ST_IMM_LO,
    ST_IMM_HI
  } dec_state_e;

  // Opcode byte patterns.
  localparam logic [7:0] BORROW_RM_MASK = 8'hFC;
  localparam logic [7:0] BORROW_RM_VAL = 8'h18;
  localparam logic [7:0] IMM_GRP_MASK = 8'hFC;
  localparam logic [7:0] IMM_GRP_VAL = 8'h80;
  localparam logic [7:0] BORROW_ACC_MASK = 8'hFE;
  localparam logic [7:0] BORROW_ACC_VAL = 8'h1C;
  localparam logic [7:0] INCDEC_MASK = 8'hFE;
  localparam logic [7:0] INCDEC_VAL = 8'hFE;
  localparam logic [7:0] COMPARE_RM_MASK = 8'hFE;
  localparam logic [7:0] COMPARE_RM_VAL = 8'h3A;
  localparam logic [7:0] UNARY_MASK = 8'hFE;
  localparam logic [7:0] UNARY_VAL = 8'hF6;
  localparam logic [7:0] IMM_MULT_MASK = 8'hFD;
  localparam logic [7:0] IMM_MULT_VAL = 8'h69;
  localparam logic [7:0] OPC_ASCII_ADD = 8'h37;
  localparam logic [7:0] OPC_DECIMAL_ADD = 8'h27;
  localparam logic [7:0] OPC_ASCII_SUB = 8'h3F;
  localparam logic [7:0] OPC_DECIMAL_SUB = 8'h2F;

  // Field positions.
  localparam int W_BIT = 0;
  localparam int S_BIT = 1;
  localparam int REG_LSB = 3;
  localparam int MOD_LSB = 6;
  localparam logic [1:0] MOD_REG = 2'h3;

  // Reg field extensions.
  localparam logic [2:0] EXT_DECREMENT = 3'h1;
  localparam logic [2:0] EXT_BORROW = 3'h3;
  localparam logic [2:0] EXT_COMPARE = 3'h7;
  localparam logic [2:0] EXT_NEGATE = 3'h3;
  localparam logic [2:0] EXT_UMULT = 3'h4;
  localparam logic [2:0] EXT_SMULT = 3'h5;
  localparam logic [2:0] EXT_DIV = 3'h6;

  // Clock counts.
  localparam logic [5:0] CLK_2 = 6'h02;
  localparam logic [5:0] CLK_3 = 6'h03;
  localparam logic [5:0] CLK_6 = 6'h06;
  localparam logic [5:0] CLK_7 = 6'h07;
  localparam logic [5:0] CLK_UMULT_RW = 6'h15;
  localparam logic [5:0] CLK_UMULT_MB = 6'h10;
  localparam logic [5:0] CLK_UMULT_MW = 6'h18;
  localparam logic [5:0] CLK_SMULT_RB = 6'h0D;
  localparam logic [5:0] CLK_IMMMUL_R = 6'h15;
  localparam logic [5:0] CLK_IMMMUL_M = 6'h18;
  localparam logic [5:0] CLK_DIV_RB = 6'h0E;
  localparam logic [5:0] CLK_DIV_RW = 6'h16;
  localparam logic [5:0] CLK_DIV_MB = 6'h11;

  typedef struct packed {
    op_kind_e kind;
    logic word_op;
    logic mem_op;
    logic [2:0] reg_field;
    logic [2:0] rm_field;
    logic [15:0] imm;
    logic [5:0] clocks;
  } decoded_s;

  typedef struct packed {
    dec_state_e st;
    logic [7:0] opcode;
    logic need_modrm_imm;
    logic imm_word;
    logic sext;
    decoded_s cur;
    decoded_s out;
    logic valid;
    logic illegal;
  } dec_regs_s;

endpackage

// >>> hdl/arith_group_opcode_decode.sv
// Decoder for the subtract-with-borrow, compare, adjust, multiply and divide opcode group.
`timescale 1ns/10ps
module arith_group_opcode_decode
  import arith_decode_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_byte_valid,
  input wire logic [7:0] i_byte,
  output logic o_byte_ready,
  output logic o_valid,
  output decoded_s o_decoded,
  output logic o_illegal
);

  dec_regs_s r_q;
  dec_regs_s r_d;

  // Clock count for the operations whose count depends on size and operand location.
  function automatic logic [5:0] unary_clocks(input op_kind_e k, input logic w, input logic m);
    logic [5:0] c;
    c = CLK_2;
    case (k)
      OP_UNSIGNED_MULTIPLY: c = m ? (w ? CLK_UMULT_MW : CLK_UMULT_MB) : CLK_UMULT_RW;
      OP_SIGNED_MULTIPLY: c = m ? (w ? CLK_UMULT_MW : CLK_UMULT_MB) : CLK_SMULT_RB;
      OP_UNSIGNED_DIVIDE: c = m ? CLK_DIV_MB : (w ? CLK_DIV_RW : CLK_DIV_RB);
      default: c = CLK_2;
    endcase
    return c;
  endfunction

  always_comb begin
    logic [1:0] md;
    logic [2:0] rg;
    logic mem;
    md = i_byte[MOD_LSB +: 2];
    rg = i_byte[REG_LSB +: 3];
    mem = (md != MOD_REG);
    r_d = r_q;
    r_d.valid = 1'b0;
    r_d.illegal = 1'b0;
    if (i_byte_valid) begin
      case (r_q.st)
        ST_OPCODE: begin
          r_d.opcode = i_byte;
          r_d.cur = '0;
          r_d.cur.word_op = i_byte[W_BIT];
          r_d.sext = 1'b0;
          r_d.need_modrm_imm = 1'b0;
          r_d.imm_word = 1'b0;
          if ((i_byte & BORROW_RM_MASK) == BORROW_RM_VAL) begin
            r_d.cur.kind = OP_SUBTRACT_WITH_BORROW;
            r_d.st = ST_MODRM;
          end else if ((i_byte & COMPARE_RM_MASK) == COMPARE_RM_VAL) begin
            r_d.cur.kind = OP_COMPARE;
            r_d.st = ST_MODRM;
          end else if ((i_byte & BORROW_ACC_MASK) == BORROW_ACC_VAL) begin
            r_d.cur.kind = OP_SUBTRACT_WITH_BORROW;
            r_d.cur.clocks = CLK_3;
            r_d.imm_word = i_byte[W_BIT];
            r_d.st = ST_IMM_LO;
          end else if ((i_byte & IMM_GRP_MASK) == IMM_GRP_VAL ||
                       (i_byte & INCDEC_MASK) == INCDEC_VAL ||
                       (i_byte & UNARY_MASK) == UNARY_VAL ||
                       (i_byte & IMM_MULT_MASK) == IMM_MULT_VAL) begin
            r_d.st = ST_MODRM;
          end else if (i_byte == OPC_ASCII_ADD || i_byte == OPC_DECIMAL_ADD ||
                       i_byte == OPC_ASCII_SUB || i_byte == OPC_DECIMAL_SUB) begin
            r_d.cur.kind = (i_byte == OPC_ASCII_ADD) ? OP_ASCII_ADJUST_ADD :
                           (i_byte == OPC_DECIMAL_ADD) ? OP_DECIMAL_ADJUST_ADD :
                           (i_byte == OPC_ASCII_SUB) ? OP_ASCII_ADJUST_SUB : OP_DECIMAL_ADJUST_SUB;
            r_d.cur.word_op = 1'b0;
            r_d.cur.clocks = CLK_3;
            r_d.out = r_d.cur;
            r_d.valid = 1'b1;
          end else begin
            r_d.illegal = 1'b1;
          end
        end
        ST_MODRM: begin
          r_d.cur.mem_op = mem;
          r_d.cur.reg_field = rg;
          r_d.cur.rm_field = i_byte[2:0];
          r_d.st = ST_OPCODE;
          if ((r_q.opcode & BORROW_RM_MASK) == BORROW_RM_VAL) begin
            r_d.cur.clocks = mem ? CLK_7 : CLK_2;
          end else if ((r_q.opcode & COMPARE_RM_MASK) == COMPARE_RM_VAL) begin
            r_d.cur.clocks = mem ? CLK_6 : CLK_2;
          end else if ((r_q.opcode & IMM_GRP_MASK) == IMM_GRP_VAL && rg == EXT_BORROW) begin
            r_d.cur.kind = OP_SUBTRACT_WITH_BORROW;
            r_d.cur.clocks = mem ? CLK_7 : CLK_3;
            r_d.imm_word = (r_q.opcode[S_BIT:W_BIT] == 2'h1);
            r_d.sext = r_q.opcode[S_BIT] & r_q.opcode[W_BIT];
            r_d.st = ST_IMM_LO;
          end else if ((r_q.opcode & IMM_GRP_MASK) == IMM_GRP_VAL && rg == EXT_COMPARE) begin
            r_d.cur.kind = OP_COMPARE;
            r_d.cur.clocks = mem ? CLK_6 : CLK_3;
            r_d.imm_word = (r_q.opcode[S_BIT:W_BIT] == 2'h1);
            r_d.sext = r_q.opcode[S_BIT] & r_q.opcode[W_BIT];
            r_d.st = ST_IMM_LO;
          end else if ((r_q.opcode & INCDEC_MASK) == INCDEC_VAL && rg == EXT_DECREMENT) begin
            r_d.cur.kind = OP_DECREMENT;
            r_d.cur.clocks = mem ? CLK_7 : CLK_2;
          end else if ((r_q.opcode & UNARY_MASK) == UNARY_VAL &&
                       (rg == EXT_NEGATE || rg == EXT_UMULT || rg == EXT_SMULT ||
                        rg == EXT_DIV)) begin
            r_d.cur.kind = (rg == EXT_NEGATE) ? OP_NEGATE :
                           (rg == EXT_UMULT) ? OP_UNSIGNED_MULTIPLY :
                           (rg == EXT_SMULT) ? OP_SIGNED_MULTIPLY :
                           OP_UNSIGNED_DIVIDE;
            r_d.cur.clocks = unary_clocks(r_d.cur.kind, r_q.cur.word_op, mem);
          end else if ((r_q.opcode & IMM_MULT_MASK) == IMM_MULT_VAL) begin
            r_d.cur.kind = OP_SIGNED_MULTIPLY_IMM;
            r_d.cur.word_op = 1'b1;
            r_d.cur.clocks = mem ? CLK_IMMMUL_M : CLK_IMMMUL_R;
            r_d.imm_word = ~r_q.opcode[S_BIT];
            r_d.sext = r_q.opcode[S_BIT];
            r_d.st = ST_IMM_LO;
          end else begin
            r_d.cur.kind = OP_NONE;
            r_d.illegal = 1'b1;
          end
          if (r_d.st == ST_OPCODE && !r_d.illegal) begin
            r_d.out = r_d.cur;
            r_d.valid = 1'b1;
          end
        end
        ST_IMM_LO: begin
          r_d.cur.imm = r_q.sext ? {{8{i_byte[7]}}, i_byte} : {8'h00, i_byte};
          if (r_q.imm_word) begin
            r_d.st = ST_IMM_HI;
          end else begin
            r_d.st = ST_OPCODE;
            r_d.out = r_d.cur;
            r_d.valid = 1'b1;
          end
        end
        ST_IMM_HI: begin
          r_d.cur.imm[15:8] = i_byte;
          r_d.st = ST_OPCODE;
          r_d.out = r_d.cur;
          r_d.valid = 1'b1;
        end
        default: r_d.st = ST_OPCODE;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign o_valid = r_q.valid;
  assign o_decoded = r_q.out;
  assign o_illegal = r_q.illegal;
  assign o_byte_ready = 1'b1;

  borrow_rm_clk_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_byte_valid && r_q.st == ST_OPCODE && (i_byte & BORROW_RM_MASK) == BORROW_RM_VAL) ##1
    (i_byte_valid && i_byte[7:6] == MOD_REG) |=> (o_valid && o_decoded.clocks == CLK_2))
    else $error("Register subtract with borrow clock count wrong.");

  borrow_imm_len_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_byte_valid && r_q.st == ST_OPCODE && i_byte == 8'h81) ##1
    (i_byte_valid && i_byte[5:3] == EXT_BORROW) |=> (r_q.st == ST_IMM_LO && r_q.imm_word))
    else $error("Word immediate subtract with borrow did not expect two bytes.");

  acc_borrow_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_byte_valid && r_q.st == ST_OPCODE && i_byte == 8'h1C) ##1 i_byte_valid
    |=> (o_valid && o_decoded.clocks == CLK_3 && o_decoded.kind == OP_SUBTRACT_WITH_BORROW))
    else $error("Accumulator subtract with borrow not decoded in 3 clocks.");

  adjust_clk_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_byte_valid && r_q.st == ST_OPCODE && i_byte == OPC_DECIMAL_ADD)
    |=> (o_valid && o_decoded.clocks == CLK_3 && o_decoded.kind == OP_DECIMAL_ADJUST_ADD))
    else $error("Decimal adjust not issued with 3 clocks.");

  umult_mem_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (o_valid && o_decoded.kind == OP_UNSIGNED_MULTIPLY && o_decoded.mem_op)
    |-> (o_decoded.clocks == (o_decoded.word_op ? CLK_UMULT_MW : CLK_UMULT_MB)))
    else $error("Unsigned multiply memory clock count wrong.");

  smult_reg_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (o_valid && o_decoded.kind == OP_SIGNED_MULTIPLY && !o_decoded.mem_op && !o_decoded.word_op)
    |-> o_decoded.clocks == CLK_SMULT_RB)
    else $error("Signed multiply register byte clock count wrong.");

  decr_clk_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_byte_valid && r_q.st == ST_OPCODE && (i_byte & INCDEC_MASK) == INCDEC_VAL) ##1
    (i_byte_valid && i_byte[5:3] == EXT_DECREMENT) |=> (o_valid &&
    o_decoded.kind == OP_DECREMENT && o_decoded.clocks == (o_decoded.mem_op ? CLK_7 : CLK_2)))
    else $error("Decrement not decoded with its clock count.");

  compare_clk_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_byte_valid && r_q.st == ST_OPCODE && (i_byte & COMPARE_RM_MASK) == COMPARE_RM_VAL) ##1
    i_byte_valid |=> (o_valid && o_decoded.kind == OP_COMPARE &&
    o_decoded.clocks == (o_decoded.mem_op ? CLK_6 : CLK_2)))
    else $error("Register compare not decoded with its clock count.");

  compare_imm_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_byte_valid && r_q.st == ST_OPCODE && (i_byte & IMM_GRP_MASK) == IMM_GRP_VAL) ##1
    (i_byte_valid && i_byte[5:3] == EXT_COMPARE) |=> (r_q.st == ST_IMM_LO &&
    r_q.cur.kind == OP_COMPARE && r_q.cur.clocks == (r_q.cur.mem_op ? CLK_6 : CLK_3)))
    else $error("Immediate compare not decoded with its clock count.");

  negate_clk_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (o_valid && o_decoded.kind == OP_NEGATE) |-> o_decoded.clocks == CLK_2)
    else $error("Negate clock count wrong.");

  umult_ext_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_byte_valid && r_q.st == ST_OPCODE && (i_byte & UNARY_MASK) == UNARY_VAL) ##1
    (i_byte_valid && i_byte[5:3] == EXT_UMULT) |=> (o_valid &&
    o_decoded.kind == OP_UNSIGNED_MULTIPLY))
    else $error("Unsigned multiply extension not decoded.");

  imm_mult_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_byte_valid && r_q.st == ST_OPCODE && i_byte == IMM_MULT_VAL) ##1 i_byte_valid
    |=> (r_q.st == ST_IMM_LO && r_q.imm_word && !r_q.sext))
    else $error("Immediate multiply did not expect a word immediate.");

  div_mem_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (o_valid && o_decoded.kind == OP_UNSIGNED_DIVIDE && o_decoded.mem_op)
    |-> o_decoded.clocks == CLK_DIV_MB)
    else $error("Unsigned divide memory clock count wrong.");

  div_clk_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (o_valid && o_decoded.kind == OP_UNSIGNED_DIVIDE && !o_decoded.mem_op)
    |-> o_decoded.clocks == (o_decoded.word_op ? CLK_DIV_RW : CLK_DIV_RB))
    else $error("Unsigned divide register clock count wrong.");

  sext_imm_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_byte_valid && r_q.st == ST_IMM_LO && r_q.sext)
    |=> (r_q.cur.imm[15:8] == {8{$past(i_byte[7])}}))
    else $error("Short immediate was not sign extended.");

endmodule // arith_group_opcode_decode

// >>> verification/prefetch_model.sv
// Behavioural instruction prefetch queue that feeds bytes to the decoder.
`timescale 1ns/10ps
module prefetch_model (
  input wire logic i_clk,
  output logic o_byte_valid,
  output logic [7:0] o_byte
);
  initial begin
    o_byte_valid = 1'b0;
    o_byte = 8'hA5;
  end

  // Bytes change at the falling edge; an idle bus shows the inverse of the last byte.
  task automatic send(input logic [7:0] q[$], input int gap);
    @(negedge i_clk);
    foreach (q[i]) begin
      o_byte_valid = 1'b1;
      o_byte = q[i];
      @(negedge i_clk);
      if (gap > 0 || i == q.size() - 1) begin
        o_byte_valid = 1'b0;
        o_byte = ~q[i];
        repeat (gap) @(negedge i_clk);
      end
    end
  endtask
endmodule // prefetch_model

// >>> verification/tb_arith_group_opcode_decode.sv
// Self-checking bench for the arithmetic group opcode decoder.
`timescale 1ns/10ps
module tb_arith_group_opcode_decode import arith_decode_pkg::*;;
  logic i_clk = 1'b0;
  logic i_rst_n;
  logic byte_valid;
  logic [7:0] byte_data;
  logic byte_ready;
  logic dec_valid;
  logic dec_illegal;
  decoded_s dec_out;
  decoded_s cap;
  logic got;
  logic ill;
  int fails = 0;
  int compares = 0;
  int cyc = 0;

  always #20 i_clk = ~i_clk;

  prefetch_model u_src (.i_clk(i_clk), .o_byte_valid(byte_valid), .o_byte(byte_data));

  arith_group_opcode_decode u_dut (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_byte_valid(byte_valid),
    .i_byte(byte_data),
    .o_byte_ready(byte_ready),
    .o_valid(dec_valid),
    .o_decoded(dec_out),
    .o_illegal(dec_illegal)
  );

  // Pulses are caught mid-cycle, where the registered outputs have settled.
  always @(negedge i_clk) begin
    if (dec_valid === 1'b1) begin
      got = 1'b1;
      cap = dec_out;
    end
    if (dec_illegal === 1'b1) ill = 1'b1;
  end

  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      $display("ERROR timeout expected 0 seen %0d", cyc);
      wrap_up();
    end
  end

  task automatic chk_bit(string name, logic exp, logic seen);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic chk_val(string name, logic [15:0] exp, logic [15:0] seen);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic run(input logic [7:0] q[$], input int gap, input op_kind_e k, input logic w,
      input logic m, input logic [5:0] n, input logic has_imm, input logic [15:0] imm);
    got = 1'b0;
    ill = 1'b0;
    u_src.send(q, gap);
    repeat (4) if (!got) @(negedge i_clk);
    chk_bit("valid", 1'b1, got);
    chk_bit("illegal", 1'b0, ill);
    chk_val("kind", 16'(k), 16'(cap.kind));
    chk_val("clocks", 16'(n), 16'(cap.clocks));
    chk_bit("word_op", w, cap.word_op);
    chk_bit("mem_op", m, cap.mem_op);
    if (has_imm) chk_val("imm", imm, cap.imm);
  endtask

  task automatic test_borrow();
    run('{8'h19, 8'hC1}, 0, OP_SUBTRACT_WITH_BORROW, 1, 0, 2, 0, 0);
    run('{8'h18, 8'h07}, 2, OP_SUBTRACT_WITH_BORROW, 0, 1, 7, 0, 0);
    run('{8'h81, 8'hDB, 8'h34, 8'h12}, 0, OP_SUBTRACT_WITH_BORROW, 1, 0, 3, 1, 16'h1234);
    run('{8'h80, 8'h1F, 8'h5A}, 1, OP_SUBTRACT_WITH_BORROW, 0, 1, 7, 1, 16'h005A);
    run('{8'h83, 8'hDB, 8'hF0}, 0, OP_SUBTRACT_WITH_BORROW, 1, 0, 3, 1, 16'hFFF0);
    run('{8'h1D, 8'h34, 8'h12}, 0, OP_SUBTRACT_WITH_BORROW, 1, 0, 3, 1, 16'h1234);
    run('{8'h1C, 8'h7F}, 3, OP_SUBTRACT_WITH_BORROW, 0, 0, 3, 1, 16'h007F);
  endtask

  task automatic test_decr_compare();
    run('{8'hFF, 8'hC9}, 0, OP_DECREMENT, 1, 0, 2, 0, 0);
    run('{8'hFE, 8'h0F}, 1, OP_DECREMENT, 0, 1, 7, 0, 0);
    run('{8'h3B, 8'hC1}, 0, OP_COMPARE, 1, 0, 2, 0, 0);
    run('{8'h3A, 8'h07}, 0, OP_COMPARE, 0, 1, 6, 0, 0);
    run('{8'h83, 8'hF8, 8'h05}, 0, OP_COMPARE, 1, 0, 3, 1, 16'h0005);
    run('{8'h81, 8'h3F, 8'h34, 8'h12}, 2, OP_COMPARE, 1, 1, 6, 1, 16'h1234);
  endtask

  task automatic test_neg_adjust();
    run('{8'hF7, 8'hD8}, 0, OP_NEGATE, 1, 0, 2, 0, 0);
    run('{8'h37}, 0, OP_ASCII_ADJUST_ADD, 0, 0, 3, 0, 0);
    run('{8'h27}, 0, OP_DECIMAL_ADJUST_ADD, 0, 0, 3, 0, 0);
    run('{8'h3F}, 0, OP_ASCII_ADJUST_SUB, 0, 0, 3, 0, 0);
    run('{8'h2F}, 0, OP_DECIMAL_ADJUST_SUB, 0, 0, 3, 0, 0);
  endtask

  task automatic test_multiply();
    run('{8'hF7, 8'hE1}, 0, OP_UNSIGNED_MULTIPLY, 1, 0, 21, 0, 0);
    run('{8'hF6, 8'h27}, 0, OP_UNSIGNED_MULTIPLY, 0, 1, 16, 0, 0);
    run('{8'hF7, 8'h27}, 1, OP_UNSIGNED_MULTIPLY, 1, 1, 24, 0, 0);
    run('{8'hF6, 8'hE9}, 0, OP_SIGNED_MULTIPLY, 0, 0, 13, 0, 0);
    run('{8'hF6, 8'h2F}, 0, OP_SIGNED_MULTIPLY, 0, 1, 16, 0, 0);
    run('{8'hF7, 8'h2F}, 0, OP_SIGNED_MULTIPLY, 1, 1, 24, 0, 0);
    run('{8'h69, 8'hC1, 8'h34, 8'h12}, 0, OP_SIGNED_MULTIPLY_IMM, 1, 0, 21, 1, 16'h1234);
    run('{8'h6B, 8'h07, 8'hF0}, 2, OP_SIGNED_MULTIPLY_IMM, 1, 1, 24, 1, 16'hFFF0);
  endtask

  task automatic test_div();
    run('{8'hF6, 8'hF1}, 0, OP_UNSIGNED_DIVIDE, 0, 0, 14, 0, 0);
    run('{8'hF7, 8'hF1}, 1, OP_UNSIGNED_DIVIDE, 1, 0, 22, 0, 0);
    run('{8'hF6, 8'h37}, 0, OP_UNSIGNED_DIVIDE, 0, 1, 17, 0, 0);
  endtask

  // An opcode outside the group and an unhandled extension must not yield a decode.
  task automatic test_illegal();
    got = 1'b0;
    ill = 1'b0;
    u_src.send('{8'h90}, 0);
    repeat (4) @(negedge i_clk);
    chk_bit("illegal_opcode", 1'b1, ill);
    chk_bit("valid_opcode", 1'b0, got);
    got = 1'b0;
    ill = 1'b0;
    u_src.send('{8'hFE, 8'hC1}, 0);
    repeat (4) @(negedge i_clk);
    chk_bit("illegal_ext", 1'b1, ill);
    chk_bit("valid_ext", 1'b0, got);
    run('{8'h37}, 0, OP_ASCII_ADJUST_ADD, 0, 0, 3, 0, 0);
  endtask

  task automatic wrap_up();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    i_rst_n = 1'b0;
    repeat (8) @(negedge i_clk);
    chk_bit("rst_valid", 1'b0, dec_valid);
    chk_val("rst_kind", 16'(OP_NONE), 16'(dec_out.kind));
    i_rst_n = 1'b1;
    chk_bit("byte_ready", 1'b1, byte_ready);
    test_borrow();
    test_decr_compare();
    test_neg_adjust();
    test_multiply();
    test_div();
    test_illegal();
    wrap_up();
  end
endmodule // tb_arith_group_opcode_decode
